// ---- core/vll_pkg.sv ----
// constants shared by the video line length configuration block
package vll_pkg;

	// --------------------------------------------------------------
	// register indices; the byte address is four times the index
	// --------------------------------------------------------------
	localparam logic [7:0] IDX_LEN_A_LO   = 8'h20;
	localparam logic [7:0] IDX_LEN_A_HI   = 8'h21;
	localparam logic [7:0] IDX_LEN_B_LO   = 8'h22;
	localparam logic [7:0] IDX_LEN_B_HI   = 8'h23;
	localparam logic [7:0] IDX_VSIZE_LO   = 8'h24;
	localparam logic [7:0] IDX_VSIZE_HI   = 8'h25;
	localparam logic [7:0] IDX_MODE_CFG   = 8'h30;
	localparam logic [7:0] IDX_MODE_STAT  = 8'h31;

	// --------------------------------------------------------------
	// bus geometry
	// --------------------------------------------------------------
	localparam int unsigned AXI_ADDR_W    = 12;
	localparam int unsigned AXI_DATA_W    = 32;
	localparam int unsigned IDX_LSB       = 2;
	localparam int unsigned IDX_MSB       = 9;
	localparam int unsigned NUM_LEN_REGS  = 6;
	localparam int unsigned LEN_W         = 12;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

	// --------------------------------------------------------------
	// mode configuration fields
	// --------------------------------------------------------------
	localparam int unsigned CFG_CHMODE_LSB = 0;
	localparam int unsigned CFG_CHMODE_MSB = 1;
	localparam int unsigned CFG_SPLIT_LR   = 2;
	localparam int unsigned CFG_ONE_LINK   = 3;
	localparam int unsigned CFG_TPG_EN     = 4;
	localparam int unsigned CFG_W          = 5;
	localparam logic [4:0]  CFG_RESET      = 5'h00;
	localparam logic [1:0]  CHMODE_DUAL_0  = 2'h0;
	localparam logic [1:0]  CHMODE_DUAL_1  = 2'h1;
	localparam logic [1:0]  CHMODE_TWO_STR = 2'h2;
	localparam logic [1:0]  CHMODE_SINGLE  = 2'h3;

	// --------------------------------------------------------------
	// status fields and reset values
	// --------------------------------------------------------------
	localparam int unsigned STAT_TWO_STR   = 0;
	localparam int unsigned STAT_SINGLE    = 1;
	localparam int unsigned STAT_ODD_EVEN  = 2;
	localparam int unsigned STAT_LEFT_RIGHT = 3;
	localparam int unsigned STAT_ODD_DUP   = 4;
	localparam int unsigned STAT_TPG       = 5;
	localparam logic [7:0]  LEN_REG_RESET  = 8'h00;

	typedef enum logic [1:0] {W_IDLE, W_HAVE_ADDR, W_HAVE_DATA, W_RESP} vll_wr_state_e;
	typedef enum logic {R_IDLE, R_RESP} vll_rd_state_e;

endpackage : vll_pkg

// ---- core/vll_reg_cell.sv ----
// one software-written configuration byte, only its low bits stored
`timescale 1ns/100ps
module vll_reg_cell
	import vll_pkg::*;
#(
	parameter int unsigned W = 8
) (
	input  wire logic         ref_clk,
	input  wire logic         rst,
	input  wire logic         wr_en,
	input  wire logic [7:0]   wr_data,
	output logic      [W-1:0] value
);

	logic [W-1:0] next_value;

	always_comb begin
		next_value = wr_en ? wr_data[W-1:0] : value;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			value <= LEN_REG_RESET[W-1:0];
		end else begin
			value <= next_value;
		end
	end

endmodule : vll_reg_cell

// ---- core/vll_line_len_cfg.sv ----
// line length, test vertical size and input mode registers behind axi4-lite
// Functional notes
// R1 - channel A line length is 12 bits, its upper four bits from bits 3:0 at 0x21.
// R2 - with one video input the channel A count is the whole active line.
// R3 - in odd/even mode A counts odd pixels, also sent to B with both links and mode 00/01.
// R4 - in left/right mode A counts the left-half pixels, sent to output A.
// R5 - in two-stream mode each channel count is the line of its own stream, A to A and B to B.
// R6 - with one video input the channel B registers are disregarded.
// R7 - in odd/even mode B counts the even pixels received on input B.
// R8 - in left/right mode B counts the right-half pixels, sent to output B.
// R9 - channel B line length is 12 bits from 0x22 (low byte) and bits 3:0 at 0x23.
// R10 - software programs A with the left pixels left after a nonzero left trim.
// R11 - software programs B with the right pixels left after a nonzero right trim.
// R12 - a 12-bit test vertical size is held in 0x24 (low byte) and bits 3:0 at 0x25.
// R13 - the vertical size is used only while the test pattern generator runs.
// R14 - channel A low byte comes from 0x20 and pairs with the nibble at 0x21.
// R15 - two-stream runs only with both links on and channel mode 10.
// R16 - outside two-stream the test pattern takes channel A timing.
// R17 - bits 7:4 of each upper-nibble register are not stored and read zero.
`timescale 1ns/100ps
module vll_line_len_cfg
	import vll_pkg::*;
(
	input  wire logic                  ref_clk,
	input  wire logic                  rst,
	input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [AXI_DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [AXI_DATA_W-1:0]      s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	output logic [LEN_W-1:0]           act_len_a,
	output logic [LEN_W-1:0]           act_len_b,
	output logic [LEN_W:0]             line_total,
	output logic                       single_active,
	output logic                       odd_even_active,
	output logic                       left_right_active,
	output logic                       two_stream_active,
	output logic                       odd_dup_to_b,
	output logic                       tpg_active,
	output logic [LEN_W-1:0]           tpg_len_a,
	output logic [LEN_W-1:0]           tpg_len_b,
	output logic [LEN_W-1:0]           tpg_vsize
);

	// --------------------------------------------------------------
	// write channel
	// --------------------------------------------------------------
	vll_wr_state_e             wr_state, next_wr_state;
	logic [AXI_ADDR_W-1:0]     waddr_q, next_waddr_q;
	logic [7:0]                wbyte_q, next_wbyte_q;
	logic                      wstrb_q, next_wstrb_q;
	logic [1:0]                bresp_q, next_bresp_q;
	logic                      aw_hs, w_hs, wr_commit, wr_strb0, wr_hit;
	logic [AXI_ADDR_W-1:0]     wr_addr;
	logic [7:0]                wr_byte;
	logic [7:0]                wr_idx;

	assign s_axi_awready = (wr_state == W_IDLE) || (wr_state == W_HAVE_DATA);
	assign s_axi_wready  = (wr_state == W_IDLE) || (wr_state == W_HAVE_ADDR);
	assign s_axi_bvalid  = (wr_state == W_RESP);
	assign s_axi_bresp   = bresp_q;
	assign aw_hs         = s_axi_awvalid && s_axi_awready;
	assign w_hs          = s_axi_wvalid && s_axi_wready;
	assign wr_addr       = aw_hs ? s_axi_awaddr : waddr_q;
	assign wr_byte       = w_hs ? s_axi_wdata[7:0] : wbyte_q;
	assign wr_strb0      = w_hs ? s_axi_wstrb[0] : wstrb_q;
	assign wr_idx        = wr_addr[IDX_MSB:IDX_LSB];

	function automatic logic idx_mapped(input logic [AXI_ADDR_W-1:0] a);
		logic [7:0] i;
		i = a[IDX_MSB:IDX_LSB];
		idx_mapped = (a[1:0] == 2'h0) && (a[AXI_ADDR_W-1:IDX_MSB+1] == 2'h0) &&
			(((i >= IDX_LEN_A_LO) && (i <= IDX_VSIZE_HI)) ||
			(i == IDX_MODE_CFG) || (i == IDX_MODE_STAT));
	endfunction : idx_mapped

	assign wr_hit = idx_mapped(wr_addr);

	always_comb begin
		next_wr_state = wr_state;
		next_waddr_q  = aw_hs ? s_axi_awaddr : waddr_q;
		next_wbyte_q  = w_hs ? s_axi_wdata[7:0] : wbyte_q;
		next_wstrb_q  = w_hs ? s_axi_wstrb[0] : wstrb_q;
		next_bresp_q  = bresp_q;
		wr_commit     = 1'b0;
		unique case (wr_state)
			W_IDLE: begin
				if (aw_hs && w_hs) begin
					wr_commit     = 1'b1;
					next_wr_state = W_RESP;
				end else if (aw_hs) begin
					next_wr_state = W_HAVE_ADDR;
				end else if (w_hs) begin
					next_wr_state = W_HAVE_DATA;
				end
			end
			W_HAVE_ADDR: begin
				if (w_hs) begin
					wr_commit     = 1'b1;
					next_wr_state = W_RESP;
				end
			end
			W_HAVE_DATA: begin
				if (aw_hs) begin
					wr_commit     = 1'b1;
					next_wr_state = W_RESP;
				end
			end
			W_RESP: begin
				if (s_axi_bready) begin
					next_wr_state = W_IDLE;
				end
			end
		endcase
		if (wr_commit) begin
			next_bresp_q = wr_hit ? RESP_OKAY : RESP_SLVERR;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wr_state <= W_IDLE;
			waddr_q  <= '0;
			wbyte_q  <= 8'h00;
			wstrb_q  <= 1'b0;
			bresp_q  <= RESP_OKAY;
		end else begin
			wr_state <= next_wr_state;
			waddr_q  <= next_waddr_q;
			wbyte_q  <= next_wbyte_q;
			wstrb_q  <= next_wstrb_q;
			bresp_q  <= next_bresp_q;
		end
	end

	// --------------------------------------------------------------
	// register storage
	// --------------------------------------------------------------
	logic [7:0] len_reg [NUM_LEN_REGS];
	logic [CFG_W-1:0] mode_cfg, next_mode_cfg;

	for (genvar g = 0; g < NUM_LEN_REGS; g++) begin : g_len
		// odd indices are the upper nibbles: only four bits stored
		localparam int unsigned CW = (g % 2 == 1) ? 4 : 8;
		logic [CW-1:0] cell_q;
		vll_reg_cell #(.W(CW)) u_cell (
			.ref_clk (ref_clk),
			.rst     (rst),
			.wr_en   (wr_commit && wr_hit && wr_strb0 &&
			          (wr_idx == IDX_LEN_A_LO + 8'(g))),
			.wr_data (wr_byte),
			.value   (cell_q)
		);
		assign len_reg[g] = 8'(cell_q); // [R17]
	end

	always_comb begin
		next_mode_cfg = mode_cfg;
		if (wr_commit && wr_hit && wr_strb0 && (wr_idx == IDX_MODE_CFG)) begin
			next_mode_cfg = wr_byte[CFG_W-1:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			mode_cfg <= CFG_RESET;
		end else begin
			mode_cfg <= next_mode_cfg;
		end
	end

	// --------------------------------------------------------------
	// mode decode and derived line values
	// --------------------------------------------------------------
	logic [1:0]       ch_mode;
	logic             one_link, split_lr;
	logic [LEN_W-1:0] raw_a, raw_b, raw_vsize;
	logic             n_single, n_two, n_oe, n_lr, n_dup, n_tpg;
	logic [LEN_W-1:0] next_len_a, next_len_b, next_tpg_a, next_tpg_b, next_vsize;
	logic [LEN_W:0]   next_total;

	assign ch_mode   = mode_cfg[CFG_CHMODE_MSB:CFG_CHMODE_LSB];
	assign one_link  = mode_cfg[CFG_ONE_LINK];
	assign split_lr  = mode_cfg[CFG_SPLIT_LR];
	assign raw_a     = {len_reg[1][3:0], len_reg[0]}; // [R1] [R14]
	assign raw_b     = {len_reg[3][3:0], len_reg[2]}; // [R9]
	assign raw_vsize = {len_reg[5][3:0], len_reg[4]}; // [R12]

	always_comb begin
		n_single = (ch_mode == CHMODE_SINGLE);
		n_two    = !one_link && (ch_mode == CHMODE_TWO_STR); // [R15]
		n_oe     = !n_single && !n_two && !split_lr; // [R7]
		n_lr     = !n_single && !n_two && split_lr; // [R4] [R8]
		n_dup    = n_oe && !one_link &&
			((ch_mode == CHMODE_DUAL_0) || (ch_mode == CHMODE_DUAL_1)); // [R3]
		n_tpg    = mode_cfg[CFG_TPG_EN];
		next_len_a = raw_a;
		next_len_b = n_single ? '0 : raw_b; // [R6]
		if (n_oe || n_lr) begin
			next_total = 13'(raw_a) + 13'(raw_b);
		end else begin
			next_total = 13'(raw_a); // [R2] [R5]
		end
		next_tpg_a = raw_a;
		next_tpg_b = n_two ? raw_b : raw_a; // [R16]
		next_vsize = n_tpg ? raw_vsize : '0; // [R13]
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			act_len_a         <= '0;
			act_len_b         <= '0;
			line_total        <= '0;
			single_active     <= 1'b0;
			odd_even_active   <= 1'b0;
			left_right_active <= 1'b0;
			two_stream_active <= 1'b0;
			odd_dup_to_b      <= 1'b0;
			tpg_active        <= 1'b0;
			tpg_len_a         <= '0;
			tpg_len_b         <= '0;
			tpg_vsize         <= '0;
		end else begin
			act_len_a         <= next_len_a;
			act_len_b         <= next_len_b;
			line_total        <= next_total;
			single_active     <= n_single;
			odd_even_active   <= n_oe;
			left_right_active <= n_lr;
			two_stream_active <= n_two;
			odd_dup_to_b      <= n_dup;
			tpg_active        <= n_tpg;
			tpg_len_a         <= next_tpg_a;
			tpg_len_b         <= next_tpg_b;
			tpg_vsize         <= next_vsize;
		end
	end

	// --------------------------------------------------------------
	// read channel
	// --------------------------------------------------------------
	vll_rd_state_e         rd_state, next_rd_state;
	logic [AXI_DATA_W-1:0] rdata_q, next_rdata_q;
	logic [1:0]            rresp_q, next_rresp_q;
	logic [7:0]            rd_idx;
	logic [7:0]            stat_byte;

	assign s_axi_arready = (rd_state == R_IDLE);
	assign s_axi_rvalid  = (rd_state == R_RESP);
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
	assign rd_idx        = s_axi_araddr[IDX_MSB:IDX_LSB];
	assign stat_byte     = {2'h0, tpg_active, odd_dup_to_b, left_right_active,
		odd_even_active, single_active, two_stream_active};

	always_comb begin
		next_rd_state = rd_state;
		next_rdata_q  = rdata_q;
		next_rresp_q  = rresp_q;
		unique case (rd_state)
			R_IDLE: begin
				if (s_axi_arvalid) begin
					next_rd_state = R_RESP;
					next_rdata_q  = '0;
					next_rresp_q  = idx_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
					if (idx_mapped(s_axi_araddr)) begin
						if (rd_idx == IDX_MODE_CFG) begin
							next_rdata_q = 32'(mode_cfg);
						end else if (rd_idx == IDX_MODE_STAT) begin
							next_rdata_q = 32'(stat_byte);
						end else begin
							next_rdata_q = 32'(len_reg[3'(rd_idx - IDX_LEN_A_LO)]);
						end
					end
				end
			end
			R_RESP: begin
				if (s_axi_rready) begin
					next_rd_state = R_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rd_state <= R_IDLE;
			rdata_q  <= '0;
			rresp_q  <= RESP_OKAY;
		end else begin
			rd_state <= next_rd_state;
			rdata_q  <= next_rdata_q;
			rresp_q  <= next_rresp_q;
		end
	end

	// --------------------------------------------------------------
	// assertions
	// --------------------------------------------------------------
	sequence s_wr_b_lo;
		wr_commit && wr_hit && wr_strb0 && (wr_idx == IDX_LEN_B_LO) && !single_active;
	endsequence

	sequence s_rd_upper;
		(rd_state == R_IDLE) && s_axi_arvalid && idx_mapped(s_axi_araddr) &&
			(rd_idx >= IDX_LEN_A_LO) && (rd_idx <= IDX_VSIZE_HI) && rd_idx[0];
	endsequence

	a_len_a_join: assert property (@(posedge ref_clk) disable iff (rst) // [R1] [R14]
		##1 act_len_a == {$past(len_reg[1][3:0]), $past(len_reg[0])})
		else $error("channel A length not formed from its two registers");
	a_single_total: assert property (@(posedge ref_clk) disable iff (rst) // [R2]
		single_active |-> (line_total == 13'(act_len_a)))
		else $error("single input line total differs from channel A count");
	a_odd_dup_route: assert property (@(posedge ref_clk) disable iff (rst) // [R3]
		odd_dup_to_b |-> (odd_even_active && !$past(one_link) && !two_stream_active))
		else $error("odd pixels duplicated to B outside dual-link odd/even");
	a_lr_total: assert property (@(posedge ref_clk) disable iff (rst) // [R4] [R8]
		(left_right_active || odd_even_active) |->
		(line_total == 13'(act_len_a) + 13'(act_len_b)))
		else $error("split mode total is not the sum of both halves");
	a_stream_sep: assert property (@(posedge ref_clk) disable iff (rst) // [R5]
		two_stream_active |-> (tpg_len_b == act_len_b) && (line_total == 13'(act_len_a)))
		else $error("two-stream channels not kept separate");
	a_b_ignored: assert property (@(posedge ref_clk) disable iff (rst) // [R6]
		single_active |-> (act_len_b == '0) && !odd_dup_to_b)
		else $error("channel B length used with one video input");
	a_b_low_write: assert property (@(posedge ref_clk) disable iff (rst) // [R9]
		s_wr_b_lo |-> ##2 ((act_len_b[7:0] == $past(wbyte_q)) || single_active))
		else $error("write to channel B low byte not seen on its length");
	a_vsize_gate: assert property (@(posedge ref_clk) disable iff (rst) // [R12] [R13]
		##1 (tpg_vsize == ($past(mode_cfg[CFG_TPG_EN]) ?
		{$past(len_reg[5][3:0]), $past(len_reg[4])} : 12'h000)))
		else $error("vertical size not gated by the test pattern enable");
	a_two_cond: assert property (@(posedge ref_clk) disable iff (rst) // [R15]
		##1 (two_stream_active ==
		(!$past(one_link) && ($past(ch_mode) == CHMODE_TWO_STR))))
		else $error("two-stream entered under the wrong link or channel mode");
	a_tpg_from_a: assert property (@(posedge ref_clk) disable iff (rst) // [R16]
		!two_stream_active |-> (tpg_len_b == tpg_len_a) && (tpg_len_a == act_len_a))
		else $error("test pattern timing not taken from channel A");
	a_upper_zero: assert property (@(posedge ref_clk) disable iff (rst) // [R17]
		s_rd_upper |=> s_axi_rvalid && (s_axi_rdata[31:4] == 28'h0000000))
		else $error("upper nibble register reads nonzero high bits");

endmodule : vll_line_len_cfg

// ---- test/vll_host_model.sv ----
// host-side bus master issuing register accesses
`timescale 1ns/100ps
module vll_host_model
	import vll_pkg::*;
(
	input  wire logic             ref_clk,
	output logic [AXI_ADDR_W-1:0] s_axi_awaddr,
	output logic                  s_axi_awvalid,
	input  wire logic             s_axi_awready,
	output logic [AXI_DATA_W-1:0] s_axi_wdata,
	output logic [3:0]            s_axi_wstrb,
	output logic                  s_axi_wvalid,
	input  wire logic             s_axi_wready,
	input  wire logic             s_axi_bvalid,
	output logic                  s_axi_bready,
	output logic [AXI_ADDR_W-1:0] s_axi_araddr,
	output logic                  s_axi_arvalid,
	input  wire logic             s_axi_arready,
	input  wire logic             s_axi_rvalid,
	output logic                  s_axi_rready
);
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
		{s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
	end

	// --------------------------------------------------------------
	// write: address and data offered together, each dropped when taken
	// --------------------------------------------------------------
	task automatic wr(input logic [AXI_ADDR_W-1:0] a, input logic [AXI_DATA_W-1:0] d,
			input logic [3:0] s, output logic to);
		int   n;
		logic b_d;
		n = 0;
		b_d = 1'b0;
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!b_d && n < 100) begin
			@(posedge ref_clk);
			n++;
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bready <= 1'b0;
				b_d = 1'b1;
			end
		end
		to = !b_d;
	endtask : wr

	// --------------------------------------------------------------
	// read: address held until taken, rready held until the answer
	// --------------------------------------------------------------
	task automatic rd(input logic [AXI_ADDR_W-1:0] a, output logic to);
		int   n;
		logic r_d;
		n = 0;
		r_d = 1'b0;
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!r_d && n < 100) begin
			@(posedge ref_clk);
			n++;
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rready <= 1'b0;
				r_d = 1'b1;
			end
		end
		to = !r_d;
	endtask : rd
endmodule : vll_host_model

// ---- test/test_video_line_length_config.sv ----
// self-checking bench for the line length configuration block
`timescale 1ns/100ps
module test_video_line_length_config
	import vll_pkg::*;
;
	logic                  ref_clk, rst;
	logic [AXI_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [AXI_DATA_W-1:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]            s_axi_wstrb;
	logic [1:0]            s_axi_bresp, s_axi_rresp;
	logic                  s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic                  s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic                  s_axi_rvalid, s_axi_rready;
	logic [LEN_W-1:0]      act_len_a, act_len_b, tpg_len_a, tpg_len_b, tpg_vsize;
	logic [LEN_W:0]        line_total;
	logic                  single_active, odd_even_active, left_right_active;
	logic                  two_stream_active, odd_dup_to_b, tpg_active;
	int                    num_errors = 0;
	int                    total_checks = 0;
	int                    seed = 23;
	logic [1:0]            exp_b[$];
	logic [33:0]           exp_r[$];
	logic [33:0]           exp_rd;
	logic [7:0]            v[6];
	logic [4:0]            cfg;
	logic                  to;

	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	vll_line_len_cfg i_vll_line_len_cfg (.ref_clk(ref_clk), .rst(rst),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .act_len_a(act_len_a),
		.act_len_b(act_len_b), .line_total(line_total), .single_active(single_active),
		.odd_even_active(odd_even_active), .left_right_active(left_right_active),
		.two_stream_active(two_stream_active), .odd_dup_to_b(odd_dup_to_b),
		.tpg_active(tpg_active), .tpg_len_a(tpg_len_a), .tpg_len_b(tpg_len_b),
		.tpg_vsize(tpg_vsize));

	vll_host_model i_vll_host_model (.ref_clk(ref_clk),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

	// --------------------------------------------------------------
	// compare, verdict and bus wrappers
	// --------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic end_sim();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_sim

	function automatic logic [11:0] ba(input logic [7:0] i);
		return {2'h0, i, 2'h0};
	endfunction : ba

	task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
			input logic [1:0] resp);
		exp_b.push_back(resp);
		i_vll_host_model.wr(a, {24'($random(seed)), d}, s, to);
		if (to) begin
			num_errors++;
			end_sim();
		end
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] resp);
		exp_r.push_back({resp, d});
		i_vll_host_model.rd(a, to);
		if (to) begin
			num_errors++;
			end_sim();
		end
	endtask : rd

	// --------------------------------------------------------------
	// mode decode expectations from the stored bytes and cfg
	// --------------------------------------------------------------
	task automatic check_modes();
		logic [11:0] a, b, vs;
		logic        sg, tw, oe, lr, dp, tp;
		a = {v[1][3:0], v[0]};
		b = {v[3][3:0], v[2]};
		vs = {v[5][3:0], v[4]};
		sg = (cfg[1:0] == CHMODE_SINGLE);
		tw = (cfg[1:0] == CHMODE_TWO_STR) && !cfg[CFG_ONE_LINK];
		lr = !sg && !tw && cfg[CFG_SPLIT_LR];
		oe = !sg && !tw && !cfg[CFG_SPLIT_LR];
		dp = oe && !cfg[CFG_ONE_LINK] && !cfg[1];
		tp = cfg[CFG_TPG_EN];
		repeat (2) @(posedge ref_clk);
		#1;
		chk("len_a", 32'(a), 32'(act_len_a));
		chk("len_b", 32'(sg ? 12'h000 : b), 32'(act_len_b));
		chk("total", 32'((oe || lr) ? 13'(a) + 13'(b) : 13'(a)), 32'(line_total));
		chk("mode", {26'h0, sg, oe, lr, tw, dp, tp}, {26'h0, single_active, odd_even_active,
			left_right_active, two_stream_active, odd_dup_to_b, tpg_active});
		chk("tpg_a", 32'(a), 32'(tpg_len_a));
		chk("tpg_b", 32'(tw ? b : a), 32'(tpg_len_b));
		chk("vsize", 32'(tp ? vs : 12'h000), 32'(tpg_vsize));
		rd(ba(IDX_MODE_STAT), {26'h0, tp, dp, lr, oe, sg, tw}, RESP_OKAY);
	endtask : check_modes

	// bus results are compared in arrival order against the noted expectations
	always @(posedge ref_clk) begin
		if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
			chk("bresp", 32'(exp_b.pop_front()), 32'(s_axi_bresp));
		if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
			exp_rd = exp_r.pop_front();
			chk("rdata", exp_rd[31:0], s_axi_rdata);
			chk("rresp", 32'(exp_rd[33:32]), 32'(s_axi_rresp));
		end
	end

	// --------------------------------------------------------------
	// main sequence
	// --------------------------------------------------------------
	initial begin
		rst = 1'b1;
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		for (int j = 0; j < 6; j++)
			v[j] = 8'h00;
		cfg = CFG_RESET;
		check_modes();
		for (int j = 0; j < 6; j++)
			rd(ba(IDX_LEN_A_LO + 8'(j)), 32'h0, RESP_OKAY);
		// lengths written are taken as already trimmed counts
		for (int k = 0; k < 3; k++) begin
			for (int j = 0; j < 6; j++) begin
				v[j] = 8'($random(seed));
				wr(ba(IDX_LEN_A_LO + 8'(j)), v[j], 4'($random(seed)) | 4'h1, RESP_OKAY);
				if (j % 2 == 1)
					v[j] = v[j] & 8'h0F;
			end
			for (int j = 0; j < 6; j++)
				rd(ba(IDX_LEN_A_LO + 8'(j)), {24'h0, v[j]}, RESP_OKAY);
			for (int c = 0; c < 32; c++) begin
				cfg = 5'(c);
				wr(ba(IDX_MODE_CFG), {3'h0, cfg}, 4'h1, RESP_OKAY);
				check_modes();
			end
		end
		// refused accesses, a write with strobe bit 0 low and a status write leave every stored byte untouched
		wr(12'h098, 8'h5A, 4'hF, RESP_SLVERR);
		rd(12'h098, 32'h0, RESP_SLVERR);
		wr(12'h081, ~v[0], 4'hF, RESP_SLVERR);
		rd(12'h081, 32'h0, RESP_SLVERR);
		wr(12'hC80, ~v[0], 4'hF, RESP_SLVERR);
		wr(ba(IDX_LEN_A_LO), ~v[0], 4'hE, RESP_OKAY);
		wr(ba(IDX_MODE_STAT), 8'hFF, 4'hF, RESP_OKAY);
		check_modes();
		// a second reset in mid-run returns every register and output to idle
		rst <= 1'b1;
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		for (int j = 0; j < 6; j++)
			v[j] = 8'h00;
		cfg = CFG_RESET;
		check_modes();
		rd(ba(IDX_LEN_B_LO), 32'h0, RESP_OKAY);
		end_sim();
	end
endmodule : test_video_line_length_config
